/* File: ssrg_host_model.sv */
// Host board model: drives the manual reset pin.
// Assumes the bench gives press requests and the polarity in use.
`timescale 1ns/10ps
module ssrg_host_model (
  // Requests
  input  wire logic press,
  input  wire logic act_low,
  // Board pin
  output logic      manual_reset_in
);
  // Level follows the selected polarity
  assign manual_reset_in = press ^ act_low;
endmodule

/* File: ssrg_monitor.sv */
// Checker of supply source, hard reset and reset output timing.
// Assumes a bind into ssrg_top, one clock domain.
`timescale 1ns/10ps
module ssrg_monitor (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Watched pins
  input wire logic       main_present,
  input wire logic       vbus_present,
  input wire logic       main_low,
  input wire logic       aux_uv,
  input wire logic [2:0] por_good,
  input wire logic       input_path_switch,
  input wire logic       vbus_path_switch,
  input wire logic       active_enable,
  input wire logic       hard_reset,
  input wire logic       sys_reset_out_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // =====
  // Hard reset pulse shape
  sequence s_pulse;
    hard_reset [*4] ##1 !hard_reset;
  endsequence
  AST_UV_RST: assert property (aux_uv [*4] |=> !sys_reset_out_n)
    else $error("reset out high under uv");
  AST_SYNC: assert property ($rose(aux_uv) && sys_reset_out_n |=> sys_reset_out_n [*2])
    else $error("uv reached reset out unsynchronized");
  AST_SRC_MAIN: assert property (
    (main_present && vbus_present && !main_low && &por_good) [*4]
    |=> input_path_switch && !vbus_path_switch) else $error("main not chosen");
  AST_SRC_VBUS: assert property ((!main_present && vbus_present && &por_good) [*4]
    |=> vbus_path_switch && !input_path_switch) else $error("vbus not chosen");
  AST_SWOVER: assert property ($fell(vbus_path_switch) && input_path_switch
    |-> (!hard_reset) [*4]) else $error("reset at switch-over");
  AST_HARD_GO: assert property ($rose(main_low) && vbus_present && input_path_switch
    |-> ##[1:5] hard_reset) else $error("no hard reset");
  AST_HARD_LEN: assert property ($rose(hard_reset) |-> s_pulse)
    else $error("hard reset pulse length");
  AST_POR: assert property ((por_good != 3'h7) [*3] |=> !active_enable)
    else $error("active while supply not good");
endmodule
bind ssrg_top ssrg_monitor i_ssrg_monitor (.pclk(pclk), .presetn(presetn),
  .main_present(main_present), .vbus_present(vbus_present), .main_low(main_low),
  .aux_uv(aux_uv), .por_good(por_good), .input_path_switch(input_path_switch),
  .vbus_path_switch(vbus_path_switch), .active_enable(active_enable),
  .hard_reset(hard_reset), .sys_reset_out_n(sys_reset_out_n));

/* File: ssrg_pkg.sv */
// Package for the supply supervisor and reset glue block.
// Assumes a 32-bit APB slave on pclk at 40 MHz.
package ssrg_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] SSRG_CTRL_OFF    = 8'h00;
  localparam logic [7:0] SSRG_STATUS_OFF  = 8'h04;
  localparam logic [7:0] SSRG_IRQ_OFF     = 8'h08;
  localparam logic [7:0] SSRG_MASK_OFF    = 8'h0c;
  localparam logic [7:0] SSRG_HOLD_OFF    = 8'h10;
  localparam logic [7:0] SSRG_THRESH_OFF  = 8'h14;

  // ==========================================================
  // Control fields
  localparam int SSRG_CTRL_POL_BIT     = 0;
  localparam int SSRG_CTRL_AUX_EN_BIT  = 1;
  localparam int SSRG_CTRL_AUX_DB_BIT  = 2;
  localparam int SSRG_CTRL_WIDTH       = 3;

  // Status fields
  localparam int SSRG_ST_SRC_MAIN_BIT  = 0;
  localparam int SSRG_ST_SRC_VBUS_BIT  = 1;
  localparam int SSRG_ST_DEADBAT_BIT   = 2;
  localparam int SSRG_ST_ACTIVE_BIT    = 3;
  localparam int SSRG_ST_UV_BIT        = 4;
  localparam int SSRG_ST_MRST_BIT      = 5;
  localparam int SSRG_ST_RSTOUT_BIT    = 6;
  localparam int SSRG_ST_AUXSW_BIT     = 7;

  // Interrupt event fields
  localparam int SSRG_EV_HARD_BIT      = 0;
  localparam int SSRG_EV_UV_BIT        = 1;
  localparam int SSRG_EV_MRST_BIT      = 2;
  localparam int SSRG_EV_SWOVER_BIT    = 3;
  localparam int SSRG_EV_WIDTH         = 4;

  // ==========================================================
  // Reset values and widths
  localparam int          SSRG_HOLD_W         = 16;
  localparam int          SSRG_THRESH_W       = 4;
  localparam logic [2:0]  SSRG_CTRL_RST       = 3'h0;
  localparam logic [15:0] SSRG_HOLD_RST       = 16'h0010;
  localparam logic [3:0]  SSRG_THRESH_RST     = 4'h8;
  localparam logic [3:0]  SSRG_MASK_RST       = 4'h0;
  localparam int          SSRG_HARD_CYC       = 4;
  localparam logic [2:0]  SSRG_HARD_CYC_W     = 3'(SSRG_HARD_CYC);

  // Source selection states
  typedef enum logic [2:0] {
    SSRG_SRC_NONE = 3'b001,
    SSRG_SRC_MAIN = 3'b010,
    SSRG_SRC_VBUS = 3'b100
  } ssrg_src_type;

endpackage

/* File: ssrg_top.sv */
// Supply supervisor, supply source tracking and system reset glue.
// Assumes comparator and POR levels arrive asynchronously from analog.
// Contract
// - Reset output low while auxiliary output under-voltage is reported.
// - Manual reset input also asserts reset output, ORed with under-voltage.
// - Manual reset active-high after reset; control bit selects active-low.
// - Firmware enable conditions drive the auxiliary supply switch.
// - Main input chosen when both present; VBUS only if main absent.
// - VBUS to main switch-over happens without any reset.
// - Main loss below 2.85 V with both present forces hard reset.
// - Active circuitry held off until every supply POR reports good.
// - Dead-battery status set whenever main input is absent.
// - Programmable threshold setting for the auxiliary output supervisor.
`timescale 1ns/10ps
module ssrg_top
  import ssrg_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog status levels
  input  wire logic        main_present,
  input  wire logic        vbus_present,
  input  wire logic        main_low,
  input  wire logic        aux_uv,
  input  wire logic [2:0]  por_good,
  input  wire logic        manual_reset_in,
  // Power and reset controls
  output logic             aux_supply_switch,
  output logic             input_path_switch,
  output logic             vbus_path_switch,
  output logic [3:0]       aux_uv_thresh,
  output logic             active_enable,
  output logic             hard_reset,
  output logic             sys_reset_out_n,
  output logic             irq
);

  // ==========================================================
  // Synchronizers
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign async_in = {por_good, manual_reset_in, aux_uv, main_low, vbus_present, main_present};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic       main_s;
  logic       vbus_s;
  logic       main_low_s;
  logic       uv_s;
  logic       mrst_raw_s;
  logic [2:0] por_s;
  assign main_s     = sync2_reg[0];
  assign vbus_s     = sync2_reg[1];
  assign main_low_s = sync2_reg[2];
  assign uv_s       = sync2_reg[3];
  assign mrst_raw_s = sync2_reg[4];
  assign por_s      = sync2_reg[7:5];

  // ==========================================================
  // Registers
  logic [SSRG_CTRL_WIDTH-1:0] ctrl_reg;
  logic [SSRG_HOLD_W-1:0]     hold_reg;
  logic [SSRG_THRESH_W-1:0]   thresh_reg;
  logic [SSRG_EV_WIDTH-1:0]   mask_reg;
  logic [SSRG_EV_WIDTH-1:0]   irq_st_reg;
  logic [SSRG_EV_WIDTH-1:0]   ev;
  logic                       wr;
  logic                       rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= SSRG_CTRL_RST;
      hold_reg   <= SSRG_HOLD_RST;
      thresh_reg <= SSRG_THRESH_RST;
      mask_reg   <= SSRG_MASK_RST;
    end else if (clk_en && wr) begin
      case (paddr)
        SSRG_CTRL_OFF:   ctrl_reg   <= pwdata[SSRG_CTRL_WIDTH-1:0];
        SSRG_HOLD_OFF:   hold_reg   <= pwdata[SSRG_HOLD_W-1:0];
        SSRG_THRESH_OFF: thresh_reg <= pwdata[SSRG_THRESH_W-1:0];
        SSRG_MASK_OFF:   mask_reg   <= pwdata[SSRG_EV_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Source selection
  ssrg_src_type src_reg;
  ssrg_src_type src_next;
  always_comb begin
    case ({main_s, vbus_s})
      2'b10, 2'b11: src_next = SSRG_SRC_MAIN;
      2'b01:        src_next = SSRG_SRC_VBUS;
      default:      src_next = SSRG_SRC_NONE;
    endcase
  end

  // VBUS to main change raises only an event, never a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= SSRG_SRC_NONE;
    end else if (clk_en) begin
      src_reg <= src_next;
    end
  end

  // ==========================================================
  // Hard reset on main loss with both present
  logic       hard_cond;
  logic [2:0] hard_cnt_reg;
  assign hard_cond = main_low_s && vbus_s && (src_reg == SSRG_SRC_MAIN);

  // Pulse stretched so the whole device sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_cnt_reg <= 3'h0;
      hard_reset   <= 1'b0;
    end else if (clk_en) begin
      if (hard_cond && hard_cnt_reg == 3'h0) begin
        hard_cnt_reg <= SSRG_HARD_CYC_W;
        hard_reset   <= 1'b1;
      end else if (hard_cnt_reg != 3'h0) begin
        hard_cnt_reg <= hard_cnt_reg - 3'h1;
        hard_reset   <= (hard_cnt_reg != 3'h1);
      end else begin
        hard_reset   <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Reset output and hold counter
  logic                   mrst_act;
  logic                   rst_src;
  logic [SSRG_HOLD_W-1:0] hold_cnt_reg;
  assign mrst_act = mrst_raw_s ^ ctrl_reg[SSRG_CTRL_POL_BIT];
  assign rst_src  = uv_s || mrst_act || hard_reset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_reg    <= SSRG_HOLD_RST;
      sys_reset_out_n <= 1'b0;
    end else if (clk_en) begin
      if (rst_src) begin
        hold_cnt_reg    <= hold_reg;
        sys_reset_out_n <= 1'b0;
      end else if (hold_cnt_reg != '0) begin
        hold_cnt_reg    <= hold_cnt_reg - 1'b1;
        sys_reset_out_n <= 1'b0;
      end else begin
        sys_reset_out_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Power controls
  logic aux_en;
  assign aux_en = ctrl_reg[SSRG_CTRL_AUX_EN_BIT] && (src_reg == SSRG_SRC_MAIN
                  || ctrl_reg[SSRG_CTRL_AUX_DB_BIT]) && main_s && !hard_reset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_supply_switch <= 1'b0;
    end else if (clk_en) begin
      aux_supply_switch <= aux_en;
    end
  end

  // Paths follow the raw choice so both paths switch on the same edge as src_reg
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_path_switch <= 1'b0;
      vbus_path_switch  <= 1'b0;
    end else if (clk_en) begin
      input_path_switch <= (src_next == SSRG_SRC_MAIN);
      vbus_path_switch  <= (src_next == SSRG_SRC_VBUS);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_enable <= 1'b0;
    end else if (clk_en) begin
      active_enable <= &por_s && !hard_reset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_uv_thresh <= SSRG_THRESH_RST;
    end else if (clk_en) begin
      aux_uv_thresh <= thresh_reg;
    end
  end

  // ==========================================================
  // Interrupts: set wins over write-one clear
  logic uv_d_reg;
  logic mrst_d_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_d_reg   <= 1'b0;
      mrst_d_reg <= 1'b0;
    end else if (clk_en) begin
      uv_d_reg   <= uv_s;
      mrst_d_reg <= mrst_act;
    end
  end

  always_comb begin
    ev = '0;
    ev[SSRG_EV_HARD_BIT]   = hard_cond && hard_cnt_reg == 3'h0;
    ev[SSRG_EV_UV_BIT]     = uv_s && !uv_d_reg;
    ev[SSRG_EV_MRST_BIT]   = mrst_act && !mrst_d_reg;
    ev[SSRG_EV_SWOVER_BIT] = src_reg == SSRG_SRC_VBUS && src_next == SSRG_SRC_MAIN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_reg <= '0;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == SSRG_IRQ_OFF) begin
        irq_st_reg <= (irq_st_reg & ~pwdata[SSRG_EV_WIDTH-1:0]) | ev;
      end else begin
        irq_st_reg <= irq_st_reg | ev;
      end
      irq <= |(irq_st_reg & mask_reg);
    end
  end

  // ==========================================================
  // APB read path, zero wait states
  logic [31:0] rdat;
  always_comb begin
    rdat = 32'h0;
    case (paddr)
      SSRG_CTRL_OFF:   rdat[SSRG_CTRL_WIDTH-1:0] = ctrl_reg;
      SSRG_STATUS_OFF: begin
        rdat[SSRG_ST_SRC_MAIN_BIT] = src_reg == SSRG_SRC_MAIN;
        rdat[SSRG_ST_SRC_VBUS_BIT] = src_reg == SSRG_SRC_VBUS;
        rdat[SSRG_ST_DEADBAT_BIT]  = !main_s;
        rdat[SSRG_ST_ACTIVE_BIT]   = active_enable;
        rdat[SSRG_ST_UV_BIT]       = uv_s;
        rdat[SSRG_ST_MRST_BIT]     = mrst_act;
        rdat[SSRG_ST_RSTOUT_BIT]   = sys_reset_out_n;
        rdat[SSRG_ST_AUXSW_BIT]    = aux_supply_switch;
      end
      SSRG_IRQ_OFF:    rdat[SSRG_EV_WIDTH-1:0] = irq_st_reg;
      SSRG_MASK_OFF:   rdat[SSRG_EV_WIDTH-1:0] = mask_reg;
      SSRG_HOLD_OFF:   rdat[SSRG_HOLD_W-1:0]   = hold_reg;
      SSRG_THRESH_OFF: rdat[SSRG_THRESH_W-1:0] = thresh_reg;
      default:         rdat = 32'h0;
    endcase
  end

  logic bad_addr;
  assign bad_addr = paddr > SSRG_THRESH_OFF || paddr[1:0] != 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && bad_addr;
      if (rd) begin
        prdata <= rdat;
      end
    end
  end

endmodule

/* File: tb_supply_supervisor_reset_glue.sv */
// Bench: APB registers, supply levels and reset pins.
// Assumes ssrg_pkg, ssrg_top, ssrg_host_model and ssrg_monitor.
`timescale 1ns/10ps
module tb_supply_supervisor_reset_glue;
  import ssrg_pkg::*;
`define CHK(n, x, g) begin samples_checked++; if ((g) !== (x)) begin n_mismatch++; \
  $display("FAIL %s exp %h got %h", n, x, g); end end
  logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, e, hr_q;
  logic [3:0]  thr_q [$];
  logic        main_present, vbus_present, main_low, aux_uv, press, act_low, manual_reset_in;
  logic        aux_supply_switch, input_path_switch, vbus_path_switch, active_enable;
  logic        hard_reset, sys_reset_out_n;
  logic [2:0]  por_good;
  logic [3:0]  aux_uv_thresh;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, lfsr;
  logic [1:0]  srcs [5] = '{2'b11, 2'b01, 2'b11, 2'b10, 2'b11};
  int          n_mismatch, samples_checked, cyc, n_hard, n;
  ssrg_top i_ssrg_top (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_present(main_present), .irq(irq),
    .vbus_present(vbus_present), .main_low(main_low), .aux_uv(aux_uv), .por_good(por_good),
    .manual_reset_in(manual_reset_in), .aux_supply_switch(aux_supply_switch),
    .input_path_switch(input_path_switch), .vbus_path_switch(vbus_path_switch),
    .aux_uv_thresh(aux_uv_thresh), .active_enable(active_enable), .hard_reset(hard_reset),
    .sys_reset_out_n(sys_reset_out_n));
  ssrg_host_model i_ssrg_host_model (.press(press), .act_low(act_low),
    .manual_reset_in(manual_reset_in));
  // =====
  // Clock, pulse counter, hang guard
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    hr_q <= hard_reset;
    if (hard_reset === 1'b1 && hr_q !== 1'b1) n_hard++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected source and dead-battery bits
  function automatic int src_m(input logic [1:0] s);
    return s[1] ? 1 : (s[0] ? 6 : 4);
  endfunction
  // Only the cycle ceiling ends a stalled access
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    apb(0, a, 0);
    `CHK("rdata", x, q & m)
  endtask
  // Bounded wait for reset out release
  task automatic wait_rel();
    n = 0;
    while (sys_reset_out_n !== 1'b1 && n < 200) begin
      n++;
      @(posedge pclk);
    end
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, main_low, aux_uv, press, act_low} = '0;
    clk_en = 1'b1;
    {main_present, vbus_present, por_good, presetn, lfsr} = {5'h1f, 1'b0, 32'hb6e4};
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(SSRG_HOLD_OFF, {16'h0, SSRG_HOLD_RST});
    rd(SSRG_THRESH_OFF, 32'h8);
    apb(0, 8'h18, 0);
    `CHK("refused", 1'b1, e)
    repeat (3) begin
      lfsr = nxt(lfsr);
      thr_q.push_back(lfsr[3:0]);
      apb(1, SSRG_THRESH_OFF, {28'h0, lfsr[3:0]});
      // Threshold pin is one register behind the write edge
      @(posedge pclk);
      `CHK("thresh", thr_q[$], aux_uv_thresh)
      rd(SSRG_THRESH_OFF, 32'(thr_q[$]));
    end
    $display("test registers done");
    apb(1, SSRG_MASK_OFF, 32'h8);
    foreach (srcs[i]) begin
      {main_present, vbus_present} <= srcs[i];
      repeat (5) @(posedge pclk);
      rd(SSRG_STATUS_OFF, src_m(srcs[i]), 32'h7);
    end
    `CHK("swover irq", 1'b1, irq)
    `CHK("no hard", 0, n_hard)
    apb(1, SSRG_IRQ_OFF, 32'h8);
    @(posedge pclk);
    `CHK("irq clear", 1'b0, irq)
    main_low <= 1;
    repeat (2) @(posedge pclk);
    main_present <= 0;
    repeat (8) @(posedge pclk);
    `CHK("hard", 1, n_hard)
    {main_present, main_low} <= 2'b10;
    $display("test source done");
    apb(1, SSRG_HOLD_OFF, 32'h6);
    wait_rel();
    aux_uv <= 1;
    repeat (4) @(posedge pclk);
    `CHK("uv reset", 1'b0, sys_reset_out_n)
    aux_uv <= 0;
    @(posedge pclk);
    wait_rel();
    `CHK("hold", 1'b1, n >= 6 && n <= 12)
    for (int i = 0; i < 2; i++) begin
      apb(1, SSRG_CTRL_OFF, 32'(i));
      act_low <= i[0];
      wait_rel();
      press <= 1;
      repeat (5) @(posedge pclk);
      `CHK("manual", 1'b0, sys_reset_out_n)
      rd(SSRG_STATUS_OFF, 32'h20, 32'h20);
      press <= 0;
      wait_rel();
      `CHK("released", 1'b1, sys_reset_out_n)
    end
    $display("test reset done");
    por_good <= 3'h3;
    repeat (5) @(posedge pclk);
    `CHK("active off", 1'b0, active_enable)
    por_good <= 3'h7;
    repeat (5) @(posedge pclk);
    `CHK("active on", 1'b1, active_enable)
    apb(1, SSRG_CTRL_OFF, 32'h3);
    @(posedge pclk);
    `CHK("aux on", 1'b1, aux_supply_switch)
    apb(1, SSRG_CTRL_OFF, 32'h1);
    @(posedge pclk);
    `CHK("aux off", 1'b0, aux_supply_switch)
    // Enable low freezes synchronizers, so a press is not seen
    clk_en <= 0;
    press  <= 1;
    repeat (6) @(posedge pclk);
    `CHK("frozen", 1'b1, sys_reset_out_n)
    clk_en <= 1;
    repeat (5) @(posedge pclk);
    `CHK("thawed", 1'b0, sys_reset_out_n)
    press <= 0;
    wait_rel();
    `CHK("refreed", 1'b1, sys_reset_out_n)
    $display("test power done");
    summarize();
  end
endmodule
